/* shared/mmtp_defs.svh */
// constants for the multimode timer block: field positions, reset values, timing counts
`ifndef MMTP_DEFS_SVH
`define MMTP_DEFS_SVH

// control byte layout
`define MMTP_CTRL_MODE_HI 7
`define MMTP_CTRL_MODE_LO 5
`define MMTP_CTRL_RUN 4
`define MMTP_CTRL_PEND_A 3
`define MMTP_CTRL_EN_A 2
`define MMTP_CTRL_PEND_B 1
`define MMTP_CTRL_EN_B 0
`define MMTP_CTRL_RST 8'h00

// data register reset value
`define MMTP_DATA_RST 16'h0000

// instruction-cycle clock is the input clock divided by this
`define MMTP_TC_DIV 10

// number of timer blocks
`define MMTP_NUM_TIMERS 3

`endif

/* shared/mmtp_pkg.sv */
// types shared by the multimode timer block
package mmtp_pkg;

   typedef enum logic [2:0] {
      MMTP_EVT_RISE = 3'b000,
      MMTP_EVT_FALL = 3'b001,
      MMTP_CAP_PP = 3'b010,
      MMTP_CAP_NP = 3'b011,
      MMTP_PWM_HOLD = 3'b100,
      MMTP_PWM_TOGGLE = 3'b101,
      MMTP_CAP_PN = 3'b110,
      MMTP_CAP_NN = 3'b111
   } mmtp_mode_t;

endpackage

/* shared/mmtp_edge_if.sv */
// carrier for a filtered pin level and its edge pulses
`timescale 1ns/1ps
interface mmtp_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

/* rtl/mmtp_tick_gen.sv */
// instruction-cycle tick generator
`timescale 1ns/1ps
`include "mmtp_defs.svh"
module mmtp_tick_gen #(
   parameter int DIV = `MMTP_TC_DIV
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // tick out
   output logic tick_q
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] div_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         tick_q <= (div_q == LAST);
         if (div_q == LAST) begin
            div_q <= '0;
         end else begin
            div_q <= div_q + CW'(1);
         end
      end
   end
endmodule

/* rtl/mmtp_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module mmtp_pin_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // raw pin
   input wire logic pin,
   // filtered level and edges
   mmtp_edge_if.src edges
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;
   logic fall_q;

   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (clk_en) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level moves only once the second and third stages agree
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (clk_en) begin
         rise_q <= (s2_q == s3_q) && s3_q && !level_q;
         fall_q <= (s2_q == s3_q) && !s3_q && level_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign edges.level = level_q;
   assign edges.rise = rise_q;
   assign edges.fall = fall_q;
endmodule

/* rtl/mmtp_top.sv */
// three multimode timer blocks: pwm, event counting and dual-edge capture
`timescale 1ns/1ps
`include "mmtp_defs.svh"
module mmtp_top #(
   parameter int NUM = `MMTP_NUM_TIMERS,
   parameter int WIDTH = 16,
   parameter int TC_DIV = `MMTP_TC_DIV
) (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // software writes to the control byte
   input wire logic [NUM-1:0] ctrl_wr,
   input wire logic [NUM-1:0][7:0] ctrl_wdata,
   // software writes to counter and data registers
   input wire logic [NUM-1:0] cnt_wr,
   input wire logic [NUM-1:0][WIDTH-1:0] cnt_wdata,
   input wire logic [NUM-1:0] rega_wr,
   input wire logic [NUM-1:0][WIDTH-1:0] rega_wdata,
   input wire logic [NUM-1:0] regb_wr,
   input wire logic [NUM-1:0][WIDTH-1:0] regb_wdata,
   // readback
   output logic [NUM-1:0][7:0] timer_control_reg_q,
   output logic [NUM-1:0][WIDTH-1:0] counter_q,
   output logic [NUM-1:0][WIDTH-1:0] reload_capture_reg_a_q,
   output logic [NUM-1:0][WIDTH-1:0] reload_capture_reg_b_q,
   // interrupt requests
   output logic [NUM-1:0] irq_a_q,
   output logic [NUM-1:0] irq_b_q,
   // timer pins
   input wire logic [NUM-1:0] timer_pin_a_in,
   output logic [NUM-1:0] timer_pin_a_out_q,
   output logic [NUM-1:0] timer_pin_a_oe_q,
   input wire logic [NUM-1:0] timer_pin_b_in
);

   // mode class decode, shared by every timer
   function automatic logic mode_is_pwm(input mmtp_pkg::mmtp_mode_t m);
      return (m == mmtp_pkg::MMTP_PWM_TOGGLE) || (m == mmtp_pkg::MMTP_PWM_HOLD);
   endfunction

   function automatic logic mode_is_evt(input mmtp_pkg::mmtp_mode_t m);
      return (m == mmtp_pkg::MMTP_EVT_RISE) || (m == mmtp_pkg::MMTP_EVT_FALL);
   endfunction

   function automatic logic mode_is_cap(input mmtp_pkg::mmtp_mode_t m);
      return !mode_is_pwm(m) && !mode_is_evt(m);
   endfunction

   logic tick;

   // one instruction-cycle tick shared by all blocks
   mmtp_tick_gen #(
      .DIV(TC_DIV)
   ) u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick_q(tick)
   );

   genvar t;
   generate
      for (t = 0; t < NUM; t++) begin : g_timer
         mmtp_edge_if edge_a ();
         mmtp_edge_if edge_b ();

         mmtp_pkg::mmtp_mode_t mode;
         logic is_pwm;
         logic is_evt;
         logic is_cap;
         logic run;
         logic step;
         logic uf;
         logic cap_a;
         logic cap_b;
         logic set_pend_a;
         logic set_pend_b;
         logic set_run;
         logic sel_b_q;
         logic [7:0] ctrl_d;

         mmtp_pin_sync u_sync_a (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .pin(timer_pin_a_in[t]),
            .edges(edge_a)
         );

         mmtp_pin_sync u_sync_b (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .pin(timer_pin_b_in[t]),
            .edges(edge_b)
         );

         // event decode from the current control byte
         always_comb begin
            mode = mmtp_pkg::mmtp_mode_t'(timer_control_reg_q[t][`MMTP_CTRL_MODE_HI:`MMTP_CTRL_MODE_LO]);
            is_pwm = mode_is_pwm(mode);
            is_evt = mode_is_evt(mode);
            is_cap = mode_is_cap(mode);
            run = timer_control_reg_q[t][`MMTP_CTRL_RUN];
            step = 1'b0;
            if (is_pwm) begin
               step = run && tick;
            end else if (is_evt) begin
               // code bit 0 picks the falling edge
               step = run && (mode[0] ? edge_a.fall : edge_a.rise);
            end else begin
               step = tick;
            end
            uf = step && (counter_q[t] == '0);
            // capture: code bit 0 negates pin a, bit 2 negates pin b
            cap_a = is_cap && (mode[0] ? edge_a.fall : edge_a.rise);
            cap_b = is_cap && (mode[2] ? edge_b.fall : edge_b.rise);
            set_pend_a = (is_pwm && uf && !sel_b_q) || (is_evt && uf) || cap_a;
            set_pend_b = (is_pwm && uf && sel_b_q) || (is_evt && edge_b.rise) || cap_b;
            set_run = is_cap && uf;
         end

         // control byte: software write, then hardware sets win over clears
         always_comb begin
            ctrl_d = ctrl_wr[t] ? ctrl_wdata[t] : timer_control_reg_q[t];
            ctrl_d[`MMTP_CTRL_RUN] = ctrl_d[`MMTP_CTRL_RUN] | set_run;
            ctrl_d[`MMTP_CTRL_PEND_A] = ctrl_d[`MMTP_CTRL_PEND_A] | set_pend_a;
            ctrl_d[`MMTP_CTRL_PEND_B] = ctrl_d[`MMTP_CTRL_PEND_B] | set_pend_b;
         end

         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               timer_control_reg_q[t] <= `MMTP_CTRL_RST;
            end else if (clk_en) begin
               timer_control_reg_q[t] <= ctrl_d;
            end
         end

         // interrupts follow the control byte as it will stand after this edge
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               irq_a_q[t] <= 1'b0;
               irq_b_q[t] <= 1'b0;
            end else if (clk_en) begin
               // capture underflow shares the pin-a request
               irq_a_q[t] <= ctrl_d[`MMTP_CTRL_EN_A] && (ctrl_d[`MMTP_CTRL_PEND_A] ||
                  (mode_is_cap(mmtp_pkg::mmtp_mode_t'(ctrl_d[`MMTP_CTRL_MODE_HI:`MMTP_CTRL_MODE_LO])) &&
                  ctrl_d[`MMTP_CTRL_RUN]));
               irq_b_q[t] <= ctrl_d[`MMTP_CTRL_EN_B] && ctrl_d[`MMTP_CTRL_PEND_B];
            end
         end

         // reload source select: stopped or non-pwm always restarts on a
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               sel_b_q <= 1'b0;
            end else if (clk_en) begin
               if (!is_pwm || !run) begin
                  sel_b_q <= 1'b0;
               end else if (uf) begin
                  sel_b_q <= !sel_b_q;
               end
            end
         end

         // counter; reset only for a known value, software must load it
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               counter_q[t] <= `MMTP_DATA_RST;
            end else if (clk_en) begin
               if (cnt_wr[t]) begin
                  counter_q[t] <= cnt_wdata[t];
               end else if (uf && is_pwm) begin
                  counter_q[t] <= sel_b_q ? reload_capture_reg_b_q[t] : reload_capture_reg_a_q[t];
               end else if (uf && is_evt) begin
                  counter_q[t] <= reload_capture_reg_a_q[t];
               end else if (step) begin
                  // capture wraps through all ones without reload
                  counter_q[t] <= counter_q[t] - WIDTH'(1);
               end
            end
         end

         // data registers; a capture wins over a same-cycle software write
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               reload_capture_reg_a_q[t] <= `MMTP_DATA_RST;
               reload_capture_reg_b_q[t] <= `MMTP_DATA_RST;
            end else if (clk_en) begin
               if (cap_a) begin
                  reload_capture_reg_a_q[t] <= counter_q[t];
               end else if (rega_wr[t]) begin
                  reload_capture_reg_a_q[t] <= rega_wdata[t];
               end
               if (cap_b) begin
                  reload_capture_reg_b_q[t] <= counter_q[t];
               end else if (regb_wr[t]) begin
                  reload_capture_reg_b_q[t] <= regb_wdata[t];
               end
            end
         end

         // pin a: driven only in pwm; input in event and capture modes
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               timer_pin_a_out_q[t] <= 1'b0;
               timer_pin_a_oe_q[t] <= 1'b0;
            end else if (clk_en) begin
               timer_pin_a_oe_q[t] <= is_pwm;
               if (uf && mode == mmtp_pkg::MMTP_PWM_TOGGLE) begin
                  timer_pin_a_out_q[t] <= !timer_pin_a_out_q[t];
               end
            end
         end
      end
   endgenerate
endmodule

/* tb/mmtp_chk.sv */
// concurrent checks on timer 0 of the three-timer block
`timescale 1ns/1ps
module mmtp_chk #(
   parameter int NUM = 3,
   parameter int WIDTH = 16,
   parameter int TC_DIV = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // software writes
   input wire logic [NUM-1:0] ctrl_wr,
   input wire logic [NUM-1:0] cnt_wr,
   // state
   input wire logic [NUM-1:0][7:0] timer_control_reg_q,
   input wire logic [NUM-1:0][WIDTH-1:0] counter_q,
   input wire logic [NUM-1:0][WIDTH-1:0] reload_capture_reg_a_q,
   input wire logic [NUM-1:0][WIDTH-1:0] reload_capture_reg_b_q,
   // requests and pin
   input wire logic [NUM-1:0] irq_a_q,
   input wire logic [NUM-1:0] irq_b_q,
   input wire logic [NUM-1:0] timer_pin_a_out_q,
   input wire logic [NUM-1:0] timer_pin_a_oe_q
);
   wire logic [7:0] c = timer_control_reg_q[0];
   wire logic [WIDTH-1:0] n = counter_q[0];
   wire logic quiet = !ctrl_wr[0] && !cnt_wr[0];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_irq_a_gate: assert property (irq_a_q[0] == (c[2] && (c[3] || (c[6] && c[4]))))
      else $error("irq a disagrees with flags");
   a_irq_b_gate: assert property (irq_b_q[0] == (c[0] && c[1]))
      else $error("irq b disagrees with flags");
   // capture codes 11x share bit 7 with pwm, so bit 6 must be low too
   a_no_pin_drive: assert property (!(c[7] && !c[6]) ##1 !(c[7] && !c[6]) |-> !timer_pin_a_oe_q[0])
      else $error("pin a driven outside pwm");
   a_pwm_pin_drive: assert property (c[7] && !c[6] ##1 c[7] && !c[6] |-> timer_pin_a_oe_q[0])
      else $error("pin a not driven in pwm");
   a_halt_holds: assert property (!c[6] && !c[4] && quiet |=> $stable(n))
      else $error("stopped counter moved");
   a_pwm_step: assert property (c[7] && !c[6] && c[4] && quiet |=>
      n == $past(n) || n == $past(n) - 1'b1 || $past(n) == 0)
      else $error("pwm count jumped");
   a_pwm_reload: assert property (c[7] && !c[6] && c[4] && n == 0 && quiet ##1 n != 0 |->
      n == reload_capture_reg_a_q[0] || n == reload_capture_reg_b_q[0])
      else $error("reload value not from a or b");
   a_pend_a_kept: assert property (c[3] && !ctrl_wr[0] |=> c[3])
      else $error("pending a dropped by itself");
   a_cap_wrap: assert property (c[6] && n == 0 && quiet |-> ##[1:TC_DIV] (n == {WIDTH{1'b1}} && c[4]))
      else $error("capture underflow did not wrap and flag");
   a_hold_no_toggle: assert property (c[7:5] == 3'b100 ##1 c[7:5] == 3'b100 |-> $stable(timer_pin_a_out_q[0]))
      else $error("pin toggled in plain pwm");
endmodule
bind mmtp_top mmtp_chk #(.NUM(NUM), .WIDTH(WIDTH), .TC_DIV(TC_DIV)) chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .ctrl_wr(ctrl_wr), .cnt_wr(cnt_wr), .timer_control_reg_q(timer_control_reg_q), .counter_q(counter_q),
   .reload_capture_reg_a_q(reload_capture_reg_a_q), .reload_capture_reg_b_q(reload_capture_reg_b_q),
   .irq_a_q(irq_a_q), .irq_b_q(irq_b_q), .timer_pin_a_out_q(timer_pin_a_out_q),
   .timer_pin_a_oe_q(timer_pin_a_oe_q));

/* tb/mmtp_pin_model.sv */
// pin-side model: external source on both timer pins, load on pin a
`timescale 1ns/1ps
module mmtp_pin_model #(
   parameter int NUM = 3
) (
   // device drive of pin a
   input wire logic [NUM-1:0] a_out,
   input wire logic [NUM-1:0] a_oe,
   // levels seen by the device
   output logic [NUM-1:0] pin_a,
   output logic [NUM-1:0] pin_b
);
   logic [NUM-1:0] src_a = '0;
   logic [NUM-1:0] src_b = '0;
   // source yields pin a while the timer drives it
   always_comb pin_a = (a_oe & a_out) | (~a_oe & src_a);
   assign pin_b = src_b;
endmodule

/* tb/tb.sv */
// self-checking bench for the three-timer block
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [2:0] ctrl_wr = '0;
   logic [2:0] cnt_wr = '0;
   logic [2:0] reg_wr = '0;
   logic [2:0][7:0] ctrl_wd = '0;
   logic [2:0][15:0] cnt_wd = '0;
   logic [2:0][15:0] ra_wd = '0;
   logic [2:0][15:0] rb_wd = '0;
   logic [2:0][7:0] ctl;
   logic [2:0][15:0] cnt, ra, rb;
   logic [2:0] irq_a, irq_b, a_out, a_oe, pin_a, pin_b;
   logic [2:0] caps [4] = '{3'b010, 3'b110, 3'b011, 3'b111};
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   always #25 clk_sys = ~clk_sys;
   // short tick divider keeps the run brief
   mmtp_top #(.TC_DIV(2)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wd), .cnt_wr(cnt_wr), .cnt_wdata(cnt_wd), .rega_wr(reg_wr), .rega_wdata(ra_wd),
      .regb_wr(reg_wr), .regb_wdata(rb_wd), .timer_control_reg_q(ctl), .counter_q(cnt),
      .reload_capture_reg_a_q(ra), .reload_capture_reg_b_q(rb), .irq_a_q(irq_a), .irq_b_q(irq_b),
      .timer_pin_a_in(pin_a), .timer_pin_a_out_q(a_out), .timer_pin_a_oe_q(a_oe), .timer_pin_b_in(pin_b));
   mmtp_pin_model pm (.a_out(a_out), .a_oe(a_oe), .pin_a(pin_a), .pin_b(pin_b));
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc_n(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic wr(input int t, input logic [7:0] c, input logic [15:0] v);
      @(negedge clk_sys);
      ctrl_wr[t] = 1'b1;
      ctrl_wd[t] = c;
      cnt_wr[t] = 1'b1;
      cnt_wd[t] = v;
      @(negedge clk_sys);
      ctrl_wr = '0;
      cnt_wr = '0;
   endtask
   task automatic wreg(input int t, input logic [15:0] a, input logic [15:0] b);
      @(negedge clk_sys);
      reg_wr[t] = 1'b1;
      ra_wd[t] = a;
      rb_wd[t] = b;
      @(negedge clk_sys);
      reg_wr = '0;
   endtask
   // pin changes need four edges to pass the synchroniser
   task automatic pin(input int t, input logic a, input logic b);
      pm.src_a[t] = a;
      pm.src_b[t] = b;
      cyc_n(8);
   endtask
   task automatic wait_f(input int t, input int b);
      int k = 0;
      while (ctl[t][b] !== 1'b1 && k < 40) begin
         @(negedge clk_sys);
         k++;
      end
      chk(16'(ctl[t][b]), 16'h0001, "flag late");
   endtask
   initial begin
      logic fa;
      logic fb;
      logic [15:0] held;
      cyc_n(2);
      reset_n = 1'b1;
      cyc_n(1);
      chk(16'(ctl[0]), 16'h0000, "ctrl reset");
      chk(cnt[0], 16'h0000, "count reset");
      chk(16'(a_oe), 16'h0000, "drive reset");
      wreg(0, 16'h0003, 16'h0001);
      wr(0, 8'hb5, 16'h0000);
      wait_f(0, 3);
      chk(cnt[0], 16'h0003, "first reload");
      chk(16'({irq_a[0], ctl[0][1], a_out[0], a_oe[0]}), 16'h000b, "pwm a");
      wait_f(0, 1);
      chk(cnt[0], 16'h0001, "second reload");
      chk(16'({irq_b[0], ctl[0][3], a_out[0]}), 16'h0006, "pwm b");
      chk(cnt[2], 16'h0000, "other timer moved");
      wr(0, 8'h8a, 16'h0007);
      cyc_n(6);
      chk(cnt[0], 16'h0007, "stopped count");
      chk(16'({ctl[0], irq_a[0], irq_b[0]}), 16'h0228, "masked irqs");
      wr(0, 8'h90, 16'h0000);
      wait_f(0, 3);
      chk(16'({cnt[0][1:0], a_out[0]}), 16'h0006, "plain pwm");
      // enable low must freeze a running count
      clk_en = 1'b0;
      held = cnt[0];
      cyc_n(6);
      chk(cnt[0], held, "frozen count");
      clk_en = 1'b1;
      pin(1, 1'b1, 1'b0);
      wreg(1, 16'h0005, 16'h0000);
      wr(1, 8'h35, 16'h0001);
      pin(1, 1'b0, 1'b0);
      chk(cnt[1], 16'h0000, "fall count");
      pin(1, 1'b1, 1'b0);
      chk(cnt[1], 16'h0000, "rise counted");
      pin(1, 1'b0, 1'b1);
      chk(cnt[1], 16'h0005, "event reload");
      chk(16'({ctl[1][3:0], irq_a[1], irq_b[1], a_oe[1]}), 16'h007e, "event flags");
      wr(1, 8'h15, 16'h0001);
      pin(1, 1'b1, 1'b1);
      chk(cnt[1], 16'h0000, "rise count");
      wr(0, 8'h00, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         fa = caps[i][0];
         fb = caps[i][2];
         pin(0, !fa, !fb);
         wreg(0, 16'h1234, 16'h1234);
         wr(0, {caps[i], 5'b00101}, 16'h0003);
         pin(0, fa, fb);
         chk(16'({ctl[0][3], ctl[0][1], ra[0] == 16'h1234, rb[0] == 16'h1234}), 16'h0003, "wrong edge");
         pin(0, !fa, !fb);
         chk(16'({ctl[0][4:0], irq_a[0], irq_b[0]}), 16'h007f, "capture flags");
         chk(16'({ra[0] - cnt[0] < 16'h0010, rb[0] - cnt[0] < 16'h0010}), 16'h0003, "captured");
      end
      wrap_up();
   end
endmodule
